// File: logic/mpd_core_map.vh
// Operation
// - Any chip reset clears the program counter to zero.
// - Low-byte write keeps PC bits 9..8; jump/call load code; return loads stack.
// - Program memory is 1024 words of 14 bits, fetched by PC or lookup.
// - Table address: current PC page or forced last page, plus lookup pointer.
// - Table read: low byte to data location, upper 6 bits to lookup_high_byte.
// - lookup_high_byte is read-only; lookup_pointer at 07H is read/write.
// - Every table read takes two instruction cycles.
// - One-entry hidden return stack; call pushes PC, return restores it.
// - Call with stack full silently overwrites the older return address.
// - Calls never save the status register, only the program counter.
// - Unassigned special locations below 20H read as 00H.
// - General RAM at 20H..3FH, 32 bytes, usable by all direct operations.
// - Location 00H redirects to the location held in the indirect pointer.
// - Indirect access with pointer 00H reads 00H and writes nothing.
// - Indirect pointer stores 7 bits; bit 7 always reads one.
// - Working register at 05H takes immediates; memory moves pass through it.
// - Status writes never change the expiry and sleep flags.
// - Bit 0 is carry / no-borrow; rotate-through-carry also updates it.
// - Bit 1 is low-nibble carry or nibble no-borrow.
// - Bit 2 is zero result; bit 3 is carry-in versus carry-out of top bit.
// - Bit 4: cleared by power-up/guard clear, set by sleep; bit 5 per watchdog.
// - PC advances by one after each fetch unless control transfers.
// - Any transfer, taken skip included, discards the fetched word for one dummy cycle.
// - Instruction cycle is four system clocks; fetch overlaps execution.
`ifndef MPD_CORE_MAP_VH
`define MPD_CORE_MAP_VH

`define MPD_PC_RESET 10'h000
`define MPD_PHASE_EXEC 2'h3
`define MPD_NOP_WORD 14'h0000

`define MPD_A_INDIRECT 7'h00
`define MPD_A_POINTER 7'h01
`define MPD_A_WORKING 7'h05
`define MPD_A_FLOW_LOW 7'h06
`define MPD_A_LOOKUP_PTR 7'h07
`define MPD_A_LOOKUP_HIGH 7'h08
`define MPD_A_GUARD_SET 7'h09
`define MPD_A_FLAGS 7'h0a
`define MPD_A_P1_DATA 7'h12
`define MPD_A_P1_DIR 7'h13
`define MPD_A_P2_DATA 7'h14
`define MPD_A_P2_DIR 7'h15
`define MPD_RAM_BASE 7'h20
`define MPD_RAM_LAST 7'h3f

`define MPD_F_CARRY 0
`define MPD_F_HALF 1
`define MPD_F_ZERO 2
`define MPD_F_RANGE 3
`define MPD_F_SLEEP 4
`define MPD_F_EXPIRY 5
`define MPD_FLAGS_SW_MASK 4'hf

`define MPD_DIR_RESET 8'hff
`define MPD_LAST_PAGE 2'h3

`define MPD_OP_MISC 4'h0
`define MPD_OP_LOAD 4'h1
`define MPD_OP_STORE 4'h2
`define MPD_OP_IMM 4'h3
`define MPD_OP_ADD 4'h4
`define MPD_OP_SUB 4'h5
`define MPD_OP_AND 4'h6
`define MPD_OP_OR 4'h7
`define MPD_OP_XOR 4'h8
`define MPD_OP_RLC 4'h9
`define MPD_OP_RRC 4'ha
`define MPD_OP_INC 4'hb
`define MPD_OP_DEC 4'hc
`define MPD_OP_TABLE 4'hd
`define MPD_OP_JUMP 4'he
`define MPD_OP_CALL 4'hf

`define MPD_MISC_NOP 3'h0
`define MPD_MISC_EXIT 3'h1
`define MPD_MISC_GCLR 3'h2
`define MPD_MISC_SLEEP 3'h3

`endif

// File: logic/mpd_core.v
`timescale 1ns/1ps
`include "mpd_core_map.vh"

module mpd_core
#(
  parameter ROM_DEPTH = 1024,
  parameter RAM_DEPTH = 32
)
(
  input wire sys_clk,
  input wire rst_n,
  input wire prog_load_en,
  input wire [9:0] prog_load_addr,
  input wire [13:0] prog_load_data,
  input wire dog_timeout,
  input wire [7:0] port_one_in,
  output wire [7:0] port_one_out,
  output wire [7:0] port_one_oe,
  input wire [7:0] port_two_in,
  output wire [7:0] port_two_out,
  output wire [7:0] port_two_oe,
  output reg [7:0] guard_timer_setting,
  output reg guard_clear_pulse,
  output reg sleep_pulse,
  output reg cycle_pulse,
  output wire [9:0] pc_out
);

  reg [1:0] phase;
  reg [9:0] pc;
  reg [13:0] ir;
  reg [9:0] return_slot;
  reg [7:0] working_register;
  reg [6:0] indirect_pointer;
  reg [7:0] lookup_pointer;
  reg [5:0] lookup_high_byte;
  reg [3:0] alu_flags;
  reg sleep_entered_flag;
  reg dog_expiry_flag;
  reg [7:0] port_one_data;
  reg [7:0] port_one_direction;
  reg [7:0] port_two_data;
  reg [7:0] port_two_direction;
  reg [7:0] p1_meta;
  reg [7:0] p1_sync;
  reg [7:0] p2_meta;
  reg [7:0] p2_sync;
  reg [13:0] rom [0:ROM_DEPTH-1];
  reg [7:0] ram [0:RAM_DEPTH-1];

  wire [3:0] opcode;
  wire [6:0] dir_addr;
  wire to_mem;
  wire [6:0] eff_addr;
  wire [7:0] operand;
  wire [9:0] table_addr;
  wire [13:0] table_word;
  wire [13:0] fetch_word;
  wire exec;

  assign exec = (phase == `MPD_PHASE_EXEC);
  assign opcode = ir[13:10];
  assign dir_addr = ir[6:0];
  assign to_mem = ir[7];
  assign eff_addr = (dir_addr == `MPD_A_INDIRECT) ? indirect_pointer : dir_addr;
  assign table_addr = {(ir[7] ? `MPD_LAST_PAGE : pc[9:8]), lookup_pointer};
  assign table_word = rom[table_addr];
  assign fetch_word = rom[pc];
  assign port_one_out = port_one_data;
  assign port_one_oe = ~port_one_direction;
  assign port_two_out = port_two_data;
  assign port_two_oe = ~port_two_direction;
  assign pc_out = pc;

  // Data-space read decode, shared by operand fetch
  function [7:0] mem_read;
    input [6:0] a;
    begin
      mem_read = 8'h00;
      case (a)
        `MPD_A_POINTER: mem_read = {1'b1, indirect_pointer};
        `MPD_A_WORKING: mem_read = working_register;
        `MPD_A_FLOW_LOW: mem_read = pc[7:0];
        `MPD_A_LOOKUP_PTR: mem_read = lookup_pointer;
        `MPD_A_LOOKUP_HIGH: mem_read = {2'b00, lookup_high_byte};
        `MPD_A_GUARD_SET: mem_read = guard_timer_setting;
        `MPD_A_FLAGS: mem_read = {2'b00, dog_expiry_flag, sleep_entered_flag, alu_flags};
        `MPD_A_P1_DATA: mem_read = (port_one_direction & p1_sync) |
                                   (~port_one_direction & port_one_data);
        `MPD_A_P1_DIR: mem_read = port_one_direction;
        `MPD_A_P2_DATA: mem_read = (port_two_direction & p2_sync) |
                                   (~port_two_direction & port_two_data);
        `MPD_A_P2_DIR: mem_read = port_two_direction;
        default:
        begin
          if (a >= `MPD_RAM_BASE && a <= `MPD_RAM_LAST)
            mem_read = ram[a[4:0]];
        end
      endcase
    end
  endfunction

  assign operand = mem_read(eff_addr);

  reg [7:0] res;
  reg res_valid;
  reg [3:0] next_flags;
  reg flags_upd;
  reg wr_en;
  reg [7:0] wr_data;
  reg acc_wr;
  reg transfer;
  reg [9:0] next_pc;
  reg push;
  reg is_table;
  reg gclr;
  reg sleep_now;
  reg [8:0] sum;
  reg [4:0] nib;
  reg c6;

  always @*
  begin
    res = 8'h00;
    res_valid = 1'b0;
    next_flags = alu_flags;
    flags_upd = 1'b0;
    wr_en = 1'b0;
    wr_data = 8'h00;
    acc_wr = 1'b0;
    transfer = 1'b0;
    next_pc = pc + 10'h001;
    push = 1'b0;
    is_table = 1'b0;
    gclr = 1'b0;
    sleep_now = 1'b0;
    sum = 9'h000;
    nib = 5'h00;
    c6 = 1'b0;
    case (opcode)
      `MPD_OP_MISC:
      begin
        if (ir[7])
        begin
          if (operand == 8'h00)
          begin
            transfer = 1'b1;
            next_pc = pc + 10'h001;
          end
        end
        else
        begin
          case (ir[2:0])
            `MPD_MISC_EXIT:
            begin
              transfer = 1'b1;
              next_pc = return_slot;
            end
            `MPD_MISC_GCLR: gclr = 1'b1;
            `MPD_MISC_SLEEP: sleep_now = 1'b1;
            default: gclr = 1'b0;
          endcase
        end
      end
      `MPD_OP_LOAD:
      begin
        acc_wr = 1'b1;
        res = operand;
      end
      `MPD_OP_STORE:
      begin
        wr_en = 1'b1;
        wr_data = working_register;
      end
      `MPD_OP_IMM:
      begin
        acc_wr = 1'b1;
        res = ir[7:0];
      end
      `MPD_OP_ADD, `MPD_OP_SUB:
      begin
        if (opcode == `MPD_OP_ADD)
        begin
          sum = {1'b0, operand} + {1'b0, working_register};
          nib = {1'b0, operand[3:0]} + {1'b0, working_register[3:0]};
          c6 = operand[6:0] + working_register[6:0] > 8'h7f;
        end
        else
        begin
          sum = {1'b0, operand} + {1'b0, ~working_register} + 9'h001;
          nib = {1'b0, operand[3:0]} + {1'b0, ~working_register[3:0]} + 5'h01;
          c6 = {1'b0, operand[6:0]} + {1'b0, ~working_register[6:0]} + 8'h01 > 8'h7f;
        end
        res = sum[7:0];
        res_valid = 1'b1;
        flags_upd = 1'b1;
        next_flags[`MPD_F_CARRY] = sum[8];
        next_flags[`MPD_F_HALF] = nib[4];
        next_flags[`MPD_F_RANGE] = c6 ^ sum[8];
        next_flags[`MPD_F_ZERO] = (sum[7:0] == 8'h00);
      end
      `MPD_OP_AND, `MPD_OP_OR, `MPD_OP_XOR, `MPD_OP_INC, `MPD_OP_DEC:
      begin
        case (opcode)
          `MPD_OP_AND: res = operand & working_register;
          `MPD_OP_OR: res = operand | working_register;
          `MPD_OP_XOR: res = operand ^ working_register;
          `MPD_OP_INC: res = operand + 8'h01;
          default: res = operand - 8'h01;
        endcase
        res_valid = 1'b1;
        flags_upd = 1'b1;
        next_flags[`MPD_F_ZERO] = (res == 8'h00);
      end
      `MPD_OP_RLC, `MPD_OP_RRC:
      begin
        if (opcode == `MPD_OP_RLC)
        begin
          res = {operand[6:0], alu_flags[`MPD_F_CARRY]};
          next_flags[`MPD_F_CARRY] = operand[7];
        end
        else
        begin
          res = {alu_flags[`MPD_F_CARRY], operand[7:1]};
          next_flags[`MPD_F_CARRY] = operand[0];
        end
        res_valid = 1'b1;
        flags_upd = 1'b1;
      end
      `MPD_OP_TABLE:
      begin
        is_table = 1'b1;
        wr_en = 1'b1;
        wr_data = table_word[7:0];
      end
      `MPD_OP_JUMP:
      begin
        transfer = 1'b1;
        next_pc = ir[9:0];
      end
      default:
      begin
        transfer = 1'b1;
        push = 1'b1;
        next_pc = ir[9:0];
      end
    endcase
    if (res_valid)
    begin
      if (to_mem)
        wr_en = 1'b1;
      else
        acc_wr = 1'b1;
      wr_data = res;
    end
    if (wr_en && eff_addr == `MPD_A_FLOW_LOW)
    begin
      transfer = 1'b1;
      next_pc = {pc[9:8], wr_data};
    end
  end

  // Instruction sequencing: one execute edge per four clocks
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase <= 2'h0;
      pc <= `MPD_PC_RESET;
      ir <= `MPD_NOP_WORD;
      return_slot <= `MPD_PC_RESET;
      cycle_pulse <= 1'b0;
      guard_clear_pulse <= 1'b0;
      sleep_pulse <= 1'b0;
    end
    else
    begin
      phase <= phase + 2'h1;
      cycle_pulse <= exec;
      guard_clear_pulse <= exec & gclr;
      sleep_pulse <= exec & sleep_now;
      if (exec)
      begin
        if (push)
          return_slot <= pc;
        if (transfer || is_table)
          ir <= `MPD_NOP_WORD;
        else
          ir <= fetch_word;
        if (!is_table)
          pc <= next_pc;
      end
    end
  end

  // Data-space writes and flags
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      working_register <= 8'h00;
      indirect_pointer <= 7'h00;
      lookup_pointer <= 8'h00;
      lookup_high_byte <= 6'h00;
      alu_flags <= 4'h0;
      sleep_entered_flag <= 1'b0;
      dog_expiry_flag <= 1'b0;
      guard_timer_setting <= 8'h00;
      port_one_data <= 8'h00;
      port_one_direction <= `MPD_DIR_RESET;
      port_two_data <= 8'h00;
      port_two_direction <= `MPD_DIR_RESET;
    end
    else
    begin
      if (exec && acc_wr)
        working_register <= res;
      if (exec && is_table)
        lookup_high_byte <= table_word[13:8];
      if (exec && wr_en)
      begin
        case (eff_addr)
          `MPD_A_INDIRECT: working_register <= working_register;
          `MPD_A_POINTER: indirect_pointer <= wr_data[6:0];
          `MPD_A_WORKING: working_register <= wr_data;
          `MPD_A_LOOKUP_PTR: lookup_pointer <= wr_data;
          `MPD_A_GUARD_SET: guard_timer_setting <= wr_data;
          `MPD_A_FLAGS: alu_flags <= wr_data[3:0] & `MPD_FLAGS_SW_MASK;
          `MPD_A_P1_DATA: port_one_data <= wr_data;
          `MPD_A_P1_DIR: port_one_direction <= wr_data;
          `MPD_A_P2_DATA: port_two_data <= wr_data;
          `MPD_A_P2_DIR: port_two_direction <= wr_data;
          default: working_register <= working_register;
        endcase
      end
      if (exec && flags_upd)
        alu_flags <= next_flags;
      if (exec && (gclr || sleep_now))
        dog_expiry_flag <= 1'b0;
      if (dog_timeout)
        dog_expiry_flag <= 1'b1;
      if (exec && gclr)
        sleep_entered_flag <= 1'b0;
      if (exec && sleep_now)
        sleep_entered_flag <= 1'b1;
    end
  end

  // General RAM and program load, no reset
  always @(posedge sys_clk)
  begin
    if (exec && wr_en && eff_addr >= `MPD_RAM_BASE && eff_addr <= `MPD_RAM_LAST)
      ram[eff_addr[4:0]] <= wr_data;
    if (prog_load_en)
      rom[prog_load_addr] <= prog_load_data;
  end

  // Pin synchronisers
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      p1_meta <= 8'h00;
      p1_sync <= 8'h00;
      p2_meta <= 8'h00;
      p2_sync <= 8'h00;
    end
    else
    begin
      p1_meta <= port_one_in;
      p1_sync <= p1_meta;
      p2_meta <= port_two_in;
      p2_sync <= p2_meta;
    end
  end

endmodule // mpd_core

// File: dv/mpd_core_props.sv
`timescale 1ns/1ps
module mpd_core_props
#(
  parameter ROM_DEPTH = 1024,
  parameter RAM_DEPTH = 32
)
(
  input wire sys_clk,
  input wire rst_n,
  input wire cycle_pulse,
  input wire guard_clear_pulse,
  input wire sleep_pulse,
  input wire [9:0] pc_out,
  input wire [7:0] port_one_out,
  input wire [7:0] port_one_oe
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  chk_pc_reset_zero:
    assert property (disable iff (1'b0) !rst_n |-> pc_out == 10'h000)
      else $error("pc not zero in reset");
  chk_first_fetch:
    assert property ($rose(rst_n) |-> (pc_out == 10'h000 && !cycle_pulse) [*4]
      ##1 (pc_out == 10'h001 && cycle_pulse)) else $error("bad first fetch");
  chk_cycle_period:
    assert property (cycle_pulse |=> !cycle_pulse [*3] ##1 cycle_pulse)
      else $error("bad cycle period");
  chk_pc_on_execute:
    assert property ($changed(pc_out) |-> cycle_pulse) else $error("pc moved off cycle");
  chk_port_on_execute:
    assert property ($changed(port_one_out) || $changed(port_one_oe) |-> cycle_pulse)
      else $error("port moved off cycle");
  chk_guard_aligned:
    assert property (guard_clear_pulse |-> cycle_pulse && !sleep_pulse)
      else $error("guard pulse misaligned");
  chk_guard_single:
    assert property (guard_clear_pulse |=> !guard_clear_pulse [*3])
      else $error("guard pulse repeated");
  chk_sleep_single:
    assert property (sleep_pulse |-> cycle_pulse ##1 !sleep_pulse [*3])
      else $error("sleep pulse bad");
endmodule // mpd_core_props

bind mpd_core mpd_core_props #(.ROM_DEPTH(ROM_DEPTH), .RAM_DEPTH(RAM_DEPTH)) u_props (
  .sys_clk(sys_clk),
  .rst_n(rst_n),
  .cycle_pulse(cycle_pulse),
  .guard_clear_pulse(guard_clear_pulse),
  .sleep_pulse(sleep_pulse),
  .pc_out(pc_out),
  .port_one_out(port_one_out),
  .port_one_oe(port_one_oe)
);

// File: dv/mpd_testbench.sv
`timescale 1ns/1ps
module testbench;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b1;
  logic prog_load_en = 1'b0;
  logic [9:0] prog_load_addr = 10'h000;
  logic [13:0] prog_load_data = 14'h0000;
  logic dog_timeout = 1'b0;
  logic [7:0] port_one_in = 8'h00;
  logic [7:0] port_two_in = 8'h00;
  wire [7:0] port_one_out, port_one_oe, port_two_out, port_two_oe, guard_timer_setting;
  wire guard_clear_pulse, sleep_pulse, cycle_pulse;
  wire [9:0] pc_out;
  int err_total = 0;
  int samples_checked = 0;
  int seed = 32'h86e9c07f;
  logic [13:0] pg[$];
  logic [7:0] a, b;
  logic [23:0] e;
  logic [13:0] d;

  always #25 sys_clk = ~sys_clk;

  mpd_core DUT (.sys_clk(sys_clk), .rst_n(rst_n), .prog_load_en(prog_load_en),
    .prog_load_addr(prog_load_addr), .prog_load_data(prog_load_data),
    .dog_timeout(dog_timeout), .port_one_in(port_one_in), .port_one_out(port_one_out),
    .port_one_oe(port_one_oe), .port_two_in(port_two_in), .port_two_out(port_two_out),
    .port_two_oe(port_two_oe), .guard_timer_setting(guard_timer_setting),
    .guard_clear_pulse(guard_clear_pulse), .sleep_pulse(sleep_pulse),
    .cycle_pulse(cycle_pulse), .pc_out(pc_out));

  function automatic [13:0] w(input [3:0] op, input [9:0] f);
    w = {op, f};
  endfunction

  // Result, flags and flag mask for one operation on [m]=x, working=y
  function automatic [23:0] alu(input [3:0] op, input [7:0] x, input [7:0] y);
    logic [8:0] r;
    logic [4:0] h;
    logic [7:0] f;
    r = op == 4'h4 ? {1'b0, x} + y : op == 4'h5 ? {1'b0, x} - y : op == 4'h6 ? x & y :
      op == 4'h7 ? x | y : op == 4'h8 ? x ^ y : op == 4'h9 ? {x[6:0], 1'b0} :
      op == 4'ha ? {1'b0, x[7:1]} : op == 4'hb ? x + 8'h01 : x - 8'h01;
    h = op == 4'h4 ? x[3:0] + y[3:0] : {1'b0, x[3:0]} - y[3:0];
    f = 8'h00;
    f[0] = op == 4'h4 ? r[8] : op == 4'h5 ? !r[8] : op == 4'h9 ? x[7] : op == 4'ha && x[0];
    f[1] = op == 4'h4 ? h[4] : op == 4'h5 && !h[4];
    f[2] = r[7:0] == 8'h00;
    f[3] = (r[7] != x[7]) && (op == 4'h4 ? x[7] == y[7] : op == 4'h5 && x[7] != y[7]);
    alu = {(op == 4'h9 || op == 4'ha) ? 8'h01 : 8'hff, f, r[7:0]};
  endfunction

  task automatic chk8(input [7:0] got, input [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk10(input [9:0] got, input [9:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic hold;
    @(negedge sys_clk);
    rst_n = 1'b0;
    port_one_in = 8'($random(seed));
    port_two_in = 8'($random(seed));
  endtask

  task automatic ld(input [9:0] base);
    foreach (pg[i])
    begin
      @(negedge sys_clk);
      prog_load_en = 1'b1;
      prog_load_addr = base + 10'(i);
      prog_load_data = pg[i];
    end
  endtask

  task automatic go(input logic dg);
    @(negedge sys_clk);
    prog_load_en = 1'b0;
    chk8(port_one_oe, 8'h00);
    chk10(pc_out, 10'h000);
    rst_n = 1'b1;
    @(negedge sys_clk);
    dog_timeout = dg;
    @(negedge sys_clk);
    dog_timeout = 1'b0;
    repeat (40) @(posedge cycle_pulse);
    @(negedge sys_clk);
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Run budget about twice the expected length
  initial
  begin
    repeat (36000) @(posedge sys_clk);
    err_total++;
    complete_run;
  end

  initial
  begin
    // Real falling edge so the asynchronous reset acts before the first clock
    #1 rst_n = 1'b0;
    repeat (4) @(negedge sys_clk);
    for (int k = 0; k < 10; k++)
      for (int op = 4; op < 13; op++)
      begin
        a = k == 0 ? 8'hff : k == 1 ? 8'h80 : 8'($random(seed));
        b = k == 0 ? 8'h01 : k == 1 ? 8'h80 : 8'($random(seed));
        e = alu(4'(op), a, b);
        hold;
        pg = '{w(4'h3, {2'b00, a}), w(4'h2, 10'h0a0), w(4'h3, {2'b00, b}), w(4'(op), 10'h020),
          w(4'h2, 10'h092), w(4'h1, 10'h00a), w(4'h2, 10'h094), w(4'he, 10'h007)};
        ld(10'h000);
        go(1'b0);
        chk8(port_one_out, e[7:0]);
        chk8(port_two_out & e[23:16], e[15:8] & e[23:16]);
      end
    a = 8'($random(seed));
    a = {a[7], 2'b01, a[4:0]};
    b = 8'($random(seed));
    hold;
    pg = '{w(4'h3, {2'b00, a}), w(4'h2, 10'h081), w(4'h3, {2'b00, b}), w(4'h2, 10'h080),
      w(4'h1, 10'h001), w(4'h2, 10'h092), w(4'h1, {3'b000, a[6:0]}), w(4'h2, 10'h094),
      w(4'h3, 10'h000), w(4'h2, 10'h081), w(4'h3, 10'h05a), w(4'h2, 10'h080),
      w(4'h1, 10'h000), w(4'h2, 10'h093), w(4'he, 10'h00e)};
    ld(10'h000);
    go(1'b0);
    chk8(port_one_out, {1'b1, a[6:0]});
    chk8(port_two_out, b);
    chk8(port_one_oe, 8'hff);
    for (int s = 0; s < 2; s++)
    begin
      a = 8'($random(seed)) | 8'h80;
      d = 14'($random(seed));
      hold;
      pg = '{d};
      ld({s == 1 ? 2'b11 : 2'b01, a});
      // Code runs in page 1 so the current-page bits are not all zero
      pg = '{w(4'he, 10'h100)};
      ld(10'h000);
      pg = '{w(4'h3, {2'b00, a}), w(4'h2, 10'h087), w(4'hd, {2'b00, s == 1, 7'h12}),
        w(4'h1, 10'h008), w(4'h2, 10'h094), w(4'h3, 10'h0ff), w(4'h2, 10'h088),
        w(4'h1, 10'h008), w(4'h2, 10'h093), w(4'he, 10'h109)};
      ld(10'h100);
      go(1'b0);
      chk8(port_one_out, d[7:0]);
      chk8(port_two_out, {2'b00, d[13:8]});
      chk8(port_one_oe, ~{2'b00, d[13:8]});
    end
    hold;
    pg = '{w(4'hf, 10'h100), w(4'h3, 10'h0ee), w(4'h2, 10'h094), w(4'he, 10'h003)};
    ld(10'h000);
    pg = '{w(4'h3, 10'h011), w(4'h2, 10'h092), w(4'hf, 10'h180), w(4'h3, 10'h022),
      w(4'h2, 10'h094), w(4'h0, 10'h001)};
    ld(10'h100);
    pg = '{w(4'h0, 10'h001)};
    ld(10'h180);
    go(1'b0);
    chk8(port_one_out, 8'h11);
    chk8(port_two_out, 8'h22);
    hold;
    pg = '{w(4'he, 10'h2f0)};
    ld(10'h000);
    pg = '{w(4'h3, 10'h040), w(4'h2, 10'h086)};
    ld(10'h2f0);
    pg = '{w(4'h3, 10'h077), w(4'h2, 10'h092), w(4'he, 10'h242)};
    ld(10'h240);
    go(1'b0);
    chk8(port_one_out, 8'h77);
    chk10({pc_out[9:1], 1'b0}, 10'h242);
    hold;
    pg = '{w(4'h3, 10'h033), w(4'h0, 10'h08b), w(4'h3, 10'h0bb), w(4'h2, 10'h092),
      w(4'h0, 10'h085), w(4'h2, 10'h094), w(4'he, 10'h006)};
    ld(10'h000);
    go(1'b0);
    chk8(port_one_out, 8'h33);
    chk8(port_two_out, 8'h33);
    hold;
    pg = '{w(4'h1, 10'h00a), w(4'h2, 10'h092), w(4'h0, 10'h003), w(4'h3, 10'h0ff),
      w(4'h2, 10'h08a), w(4'h1, 10'h00a), w(4'h2, 10'h094), w(4'h0, 10'h002),
      w(4'h1, 10'h00a), w(4'h2, 10'h093), w(4'h2, 10'h089), w(4'h1, 10'h014),
      w(4'h2, 10'h095), w(4'he, 10'h00d)};
    ld(10'h000);
    go(1'b1);
    chk8(port_one_out, 8'h20);
    chk8(port_two_out, 8'h1f);
    chk8(port_one_oe, 8'hf0);
    chk8(guard_timer_setting, 8'h0f);
    chk8(port_two_oe, ~port_two_in);
    complete_run;
  end
endmodule // testbench
